// ### logic/lcfs_supervisor.v
// Loop channel fault supervisor: fault coding, blink bursts, alignment limit and records.
// Notes on behaviour
// - Faulty channel LED blinks a coded burst, repeated every 5 seconds.
// - Blink count 1 shorted loop, 2 open loop, 3 frequency unreachable.
// - Blink count 7 alignment time exceeded, 8 unsupported loop type.
// - Collective fault LED and fault output high while any channel faults.
// - Unequal frequency jumpers flag a 5-blink fault on every channel.
// - Interference during alignment, over about 2 s, flags 4 blinks.
// - Alignment stopped at configured maximum duration of up to 65 s, raising the timeout fault.
// - Auto recalibration flag, clear at reset, re-aligns faulty channels cyclically.
// - Recalibration never clears jumper or loop type faults.
// - Faulty loop of a pair puts the other in standby, two classes.
// - Each vehicle record carries system, class, speed, length, direction, distance.
// - Width 16 gives four rows per record; width above 63 gives one.
// - Norm values and thresholds are continually stored to non-volatile storage.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`include "lcfs_map.vh"
module lcfs_supervisor #(
  parameter NCH = 4,
  parameter MS_CYCLES = `LCFS_MS_CYCLES
) (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [NCH-1:0] meas_short,
  input wire [NCH-1:0] meas_open,
  input wire [NCH-1:0] meas_freq_fail,
  input wire [NCH-1:0] meas_interference,
  input wire [NCH-1:0] meas_done,
  input wire [NCH-1:0] loop_type_bad,
  input wire jumper_a,
  input wire jumper_b,
  input wire [NCH-1:0] align_request,
  output reg [NCH-1:0] align_active,
  output reg [NCH-1:0] channel_indicator_leds,
  output reg fault_led,
  output reg fault_out,
  output reg [NCH-1:0] standby,
  output reg [NCH-1:0] reduced_class,
  input wire veh_valid,
  input wire [1:0] veh_system,
  input wire [3:0] veh_class,
  input wire [15:0] veh_speed,
  input wire [15:0] veh_length,
  input wire veh_direction,
  input wire [15:0] veh_distance,
  output reg rec_valid,
  output reg [1:0] rec_system,
  output reg [3:0] rec_class,
  output reg [15:0] rec_speed,
  output reg [15:0] rec_length,
  output reg rec_direction,
  output reg [15:0] rec_distance,
  output reg [2:0] rec_rows,
  output reg nv_store,
  output reg [7:0] nv_addr,
  output reg [15:0] nv_data
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Jumpers and loop type switches are slow pins from outside the clock domain.
  // Two flops keep metastability away from the fault flags that read them.
  reg [1:0] jmp_s1_q;
  reg [1:0] jmp_s2_q;
  reg [NCH-1:0] lt_s1_q;
  reg [NCH-1:0] lt_s2_q;
  always @(posedge ref_clk) begin
    if (rst) begin
      jmp_s1_q <= 2'h0;
      jmp_s2_q <= 2'h0;
      lt_s1_q <= {NCH{1'b0}};
      lt_s2_q <= {NCH{1'b0}};
    end else begin
      jmp_s1_q <= {jumper_b, jumper_a};
      jmp_s2_q <= jmp_s1_q;
      lt_s1_q <= loop_type_bad;
      lt_s2_q <= lt_s1_q;
    end
  end
  wire jumper_mismatch = jmp_s2_q[0] ^ jmp_s2_q[1];

  // --------------------------------------------------------------------------
  // Millisecond tick
  // --------------------------------------------------------------------------
  // All fault timing counts in milliseconds, so only this divider knows the clock rate.
  // With a count of one the tick is high on every cycle, which speeds up simulation.
  reg [15:0] ms_cnt_q;
  wire ms_tick = (ms_cnt_q == MS_CYCLES - 1);
  always @(posedge ref_clk) begin
    if (rst || ms_tick) begin
      ms_cnt_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Control writes keep only the per-channel recalibration enables. The alignment
  // start bits and the recover bit act as one-cycle commands and are never stored.
  reg [31:0] ctrl_q;
  reg [15:0] maxalign_q;
  reg [7:0] termw_q;
  reg [15:0] norm_q [0:NCH-1];
  reg [15:0] thr_q [0:NCH-1];
  reg [NCH-1:0] f_short_q;
  reg [NCH-1:0] f_open_q;
  reg [NCH-1:0] f_freq_q;
  reg [NCH-1:0] f_dist_q;
  reg [NCH-1:0] f_jmp_q;
  reg [NCH-1:0] f_to_q;
  reg [NCH-1:0] f_lt_q;
  reg [3:0] code [0:NCH-1];
  wire [NCH-1:0] recal_en = ctrl_q[`LCFS_CTRL_RECAL_LSB +: NCH];
  wire [NCH-1:0] sw_align = reg_wr && reg_addr == `LCFS_REG_CTRL ?
                            reg_wdata[`LCFS_CTRL_ALIGN_LSB +: NCH] : {NCH{1'b0}};
  wire recover = reg_wr && reg_addr == `LCFS_REG_CTRL && reg_wdata[`LCFS_CTRL_RECOVER_BIT];
  wire [NCH-1:0] any_fault = f_short_q | f_open_q | f_freq_q | f_dist_q | f_jmp_q |
                             f_to_q | f_lt_q;
  // Each process has its own loop index so that no variable has two drivers.
  integer i;
  integer ir;
  integer ia;
  integer ic;
  integer il;

  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= `LCFS_CTRL_RST_VAL;
      maxalign_q <= `LCFS_MAXALIGN_RST_VAL;
      termw_q <= `LCFS_TERMW_RST_VAL;
      for (i = 0; i < NCH; i = i + 1) begin
        norm_q[i] <= 16'h0000;
        thr_q[i] <= 16'h0000;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `LCFS_REG_CTRL: ctrl_q <= {24'h000000, 4'h0, reg_wdata[3:0]};
        `LCFS_REG_MAXALIGN: maxalign_q <= reg_wdata[15:0];
        `LCFS_REG_TERMW: termw_q <= reg_wdata[7:0];
        default: begin
          for (i = 0; i < NCH; i = i + 1) begin
            if (reg_addr == `LCFS_REG_NORM_BASE + 4 * i) norm_q[i] <= reg_wdata[15:0];
            if (reg_addr == `LCFS_REG_THR_BASE + 4 * i) thr_q[i] <= reg_wdata[15:0];
          end
        end
      endcase
    end
  end

  // Read data stand for one cycle after the read strobe and are zero otherwise.
  // Unmapped offsets answer zero.
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `LCFS_REG_CTRL: reg_rdata <= ctrl_q;
          `LCFS_REG_MAXALIGN: reg_rdata <= {16'h0000, maxalign_q};
          `LCFS_REG_FAULT: reg_rdata <= {16'h0000, code[3], code[2], code[1], code[0]};
          `LCFS_REG_STATUS: reg_rdata <= {20'h00000, reduced_class, align_active, any_fault};
          `LCFS_REG_TERMW: reg_rdata <= {24'h000000, termw_q};
          default: begin
            for (ir = 0; ir < NCH; ir = ir + 1) begin
              if (reg_addr == `LCFS_REG_NORM_BASE + 4 * ir) reg_rdata <= {16'h0000, norm_q[ir]};
              if (reg_addr == `LCFS_REG_THR_BASE + 4 * ir) reg_rdata <= {16'h0000, thr_q[ir]};
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Alignment control and fault flags
  // --------------------------------------------------------------------------
  // Every channel aligns after reset, as at power-on. A channel aligns again on a
  // request pin, a software start, a recover command or the recalibration timer.
  // The jumper and loop type flags follow their cause and only a recover command
  // clears them; a cause still present in the same cycle wins over the clear.
  reg [15:0] align_ms_q [0:NCH-1];
  reg [15:0] recal_ms_q [0:NCH-1];
  reg [NCH-1:0] recal_go;
  always @(posedge ref_clk) begin
    if (rst) begin
      align_active <= {NCH{1'b1}};
      f_short_q <= {NCH{1'b0}};
      f_open_q <= {NCH{1'b0}};
      f_freq_q <= {NCH{1'b0}};
      f_dist_q <= {NCH{1'b0}};
      f_jmp_q <= {NCH{1'b0}};
      f_to_q <= {NCH{1'b0}};
      f_lt_q <= {NCH{1'b0}};
      recal_go <= {NCH{1'b0}};
      for (ia = 0; ia < NCH; ia = ia + 1) begin
        align_ms_q[ia] <= 16'h0000;
        recal_ms_q[ia] <= 16'h0000;
      end
    end else begin
      for (ia = 0; ia < NCH; ia = ia + 1) begin
        f_jmp_q[ia] <= jumper_mismatch | (f_jmp_q[ia] & ~recover);
        f_lt_q[ia] <= lt_s2_q[ia] | (f_lt_q[ia] & ~recover);
        recal_go[ia] <= 1'b0;
        if (recal_en[ia] && any_fault[ia] && !align_active[ia]) begin
          if (ms_tick) recal_ms_q[ia] <= recal_ms_q[ia] + 16'h0001;
          if (recal_ms_q[ia] >= `LCFS_RECAL_MS) begin
            recal_ms_q[ia] <= 16'h0000;
            recal_go[ia] <= 1'b1;
          end
        end else begin
          recal_ms_q[ia] <= 16'h0000;
        end
        if (!align_active[ia]) begin
          if (align_request[ia] || sw_align[ia] || recover || recal_go[ia]) begin
            align_active[ia] <= 1'b1;
            align_ms_q[ia] <= 16'h0000;
          end
        end else begin
          if (ms_tick) align_ms_q[ia] <= align_ms_q[ia] + 16'h0001;
          if (align_ms_q[ia] >= `LCFS_DISTURB_MS && meas_interference[ia])
            f_dist_q[ia] <= 1'b1;
          if (meas_done[ia]) begin
            align_active[ia] <= 1'b0;
            f_short_q[ia] <= meas_short[ia];
            f_open_q[ia] <= meas_open[ia];
            f_freq_q[ia] <= meas_freq_fail[ia];
            f_dist_q[ia] <= meas_interference[ia] && align_ms_q[ia] >= `LCFS_DISTURB_MS;
            f_to_q[ia] <= 1'b0;
          end else if ({16'h0000, align_ms_q[ia]} >= maxalign_q * 32'd1000) begin
            align_active[ia] <= 1'b0;
            f_to_q[ia] <= 1'b1;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Fault code selection and blink bursts
  // --------------------------------------------------------------------------
  // Only one code is shown per burst; the priority order below follows the
  // blink counts, so the fault with the fewest blinks is the one shown.
  always @* begin
    for (ic = 0; ic < NCH; ic = ic + 1) begin
      if (f_short_q[ic]) code[ic] = `LCFS_CODE_SHORT;
      else if (f_open_q[ic]) code[ic] = `LCFS_CODE_OPEN;
      else if (f_freq_q[ic]) code[ic] = `LCFS_CODE_FREQ;
      else if (f_dist_q[ic]) code[ic] = `LCFS_CODE_DISTURB;
      else if (f_jmp_q[ic]) code[ic] = `LCFS_CODE_JUMPER;
      else if (f_to_q[ic]) code[ic] = `LCFS_CODE_TIMEOUT;
      else if (f_lt_q[ic]) code[ic] = `LCFS_CODE_LOOPTYPE;
      else code[ic] = `LCFS_CODE_NONE;
    end
  end

  // One burst period is shared by all channels, so their bursts start together.
  // Each blink slot is lit in even slots while half the slot number is below the code.
  reg [12:0] burst_ms_q;
  always @(posedge ref_clk) begin
    if (rst || (ms_tick && burst_ms_q == `LCFS_BURST_PERIOD_MS - 1)) begin
      burst_ms_q <= 13'h0000;
    end else if (ms_tick) begin
      burst_ms_q <= burst_ms_q + 13'h0001;
    end
  end
  wire [31:0] slot_wide = {19'h00000, burst_ms_q} / `LCFS_BLINK_MS;
  wire [12:0] slot = slot_wide[12:0];

  // A channel under alignment shows a steady light; a pair partner of a faulty
  // loop drops to standby with the reduced two-class classification.
  always @(posedge ref_clk) begin
    if (rst) begin
      channel_indicator_leds <= {NCH{1'b0}};
      fault_led <= 1'b0;
      fault_out <= 1'b0;
      standby <= {NCH{1'b0}};
      reduced_class <= {NCH{1'b0}};
    end else begin
      for (il = 0; il < NCH; il = il + 1) begin
        if (align_active[il]) channel_indicator_leds[il] <= 1'b1;
        else if (any_fault[il])
          channel_indicator_leds[il] <= !slot[0] && (slot[12:1] < code[il]);
        else channel_indicator_leds[il] <= 1'b0;
        standby[il] <= !any_fault[il] && any_fault[il ^ 1];
        reduced_class[il] <= !any_fault[il] && any_fault[il ^ 1];
      end
      fault_led <= |any_fault;
      fault_out <= |any_fault;
    end
  end

  // --------------------------------------------------------------------------
  // Vehicle records and non-volatile store
  // --------------------------------------------------------------------------
  // The record is a registered copy of the vehicle data, issued one cycle later.
  // The store walks norm and threshold of every channel, one word per millisecond.
  reg [2:0] nv_idx_q;
  always @(posedge ref_clk) begin
    if (rst) begin
      rec_valid <= 1'b0;
      rec_system <= 2'h0;
      rec_class <= 4'h0;
      rec_speed <= 16'h0000;
      rec_length <= 16'h0000;
      rec_direction <= 1'b0;
      rec_distance <= 16'h0000;
      rec_rows <= `LCFS_ROWS_NARROW;
      nv_store <= 1'b0;
      nv_addr <= 8'h00;
      nv_data <= 16'h0000;
      nv_idx_q <= 3'h0;
    end else begin
      rec_valid <= veh_valid;
      if (veh_valid) begin
        rec_system <= veh_system;
        rec_class <= veh_class;
        rec_speed <= veh_speed;
        rec_length <= veh_length;
        rec_direction <= veh_direction;
        rec_distance <= veh_distance;
        rec_rows <= termw_q > `LCFS_TERMW_WIDE ? `LCFS_ROWS_WIDE : `LCFS_ROWS_NARROW;
      end
      // The lowest index bit picks threshold over norm, the upper bits the channel.
      nv_store <= ms_tick;
      if (ms_tick) begin
        nv_idx_q <= nv_idx_q + 3'h1;
        nv_addr <= {5'h00, nv_idx_q};
        nv_data <= nv_idx_q[0] ? thr_q[nv_idx_q[2:1]] : norm_q[nv_idx_q[2:1]];
      end
    end
  end
endmodule // lcfs_supervisor

// ### logic/lcfs_map.vh
// Register offsets, field positions, reset values and timing counts of the fault supervisor.
`ifndef LCFS_MAP_VH
`define LCFS_MAP_VH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LCFS_REG_CTRL 8'h00
`define LCFS_REG_MAXALIGN 8'h04
`define LCFS_REG_FAULT 8'h08
`define LCFS_REG_STATUS 8'h0c
`define LCFS_REG_NORM_BASE 8'h10
`define LCFS_REG_THR_BASE 8'h20
`define LCFS_REG_TERMW 8'h30
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LCFS_CTRL_RECAL_LSB 0
`define LCFS_CTRL_ALIGN_LSB 4
`define LCFS_CTRL_RECOVER_BIT 8
`define LCFS_CTRL_RST_VAL 32'h0000_0000
`define LCFS_MAXALIGN_RST_VAL 16'h000a
`define LCFS_TERMW_RST_VAL 8'h10
`define LCFS_TERMW_WIDE 8'h3f
`define LCFS_ROWS_NARROW 3'h4
`define LCFS_ROWS_WIDE 3'h1
// ----------------------------------------------------------------------------
// Blink counts per fault
// ----------------------------------------------------------------------------
`define LCFS_CODE_NONE 4'h0
`define LCFS_CODE_SHORT 4'h1
`define LCFS_CODE_OPEN 4'h2
`define LCFS_CODE_FREQ 4'h3
`define LCFS_CODE_DISTURB 4'h4
`define LCFS_CODE_JUMPER 4'h5
`define LCFS_CODE_TIMEOUT 4'h7
`define LCFS_CODE_LOOPTYPE 4'h8
// ----------------------------------------------------------------------------
// Timing (clock 25 MHz)
// ----------------------------------------------------------------------------
`define LCFS_CLK_HZ 25000000
`define LCFS_BURST_PERIOD_MS 5000
`define LCFS_BLINK_MS 200
`define LCFS_DISTURB_MS 2000
`define LCFS_RECAL_MS 30000
`define LCFS_MS_CYCLES (`LCFS_CLK_HZ / 1000)
`endif

// ### testbench/lcfs_supervisor_sva.sv
// Port-level assertions for the loop channel fault supervisor.
module lcfs_sva #(
  parameter NCH = 4
) (
  input wire ref_clk,
  input wire rst,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [NCH-1:0] align_active,
  input wire [NCH-1:0] channel_indicator_leds,
  input wire fault_led,
  input wire fault_out,
  input wire [NCH-1:0] standby,
  input wire [NCH-1:0] reduced_class,
  input wire veh_valid,
  input wire [3:0] veh_class,
  input wire [15:0] veh_speed,
  input wire rec_valid,
  input wire [3:0] rec_class,
  input wire [15:0] rec_speed,
  input wire [2:0] rec_rows
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_veh;
    veh_valid ##1 rec_valid;
  endsequence
  a_fault_lines_eq: assert property (fault_led == fault_out)
    else $error("fault led and fault output differ");
  a_rec_pulse: assert property (veh_valid |=> rec_valid)
    else $error("record not issued after vehicle");
  a_rec_lone: assert property (!veh_valid |=> !rec_valid)
    else $error("record issued without vehicle");
  a_rec_fields: assert property (s_veh |->
    rec_class == $past(veh_class) && rec_speed == $past(veh_speed))
    else $error("record fields differ from vehicle");
  a_rows_legal: assert property (rec_rows == 3'h4 || rec_rows == 3'h1)
    else $error("row count not four or one");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  a_standby_class: assert property (standby == reduced_class)
    else $error("standby and reduced class differ");
  a_pair_single: assert property (!(standby[0] && standby[1]) && !(standby[2] && standby[3]))
    else $error("both loops of a pair in standby");
  a_align_led: assert property (!$past(rst) |->
    (align_active & $past(align_active) & ~channel_indicator_leds) == 4'h0)
    else $error("channel led dark during alignment");
  a_quiet_dark: assert property (!fault_led && !$past(fault_led) && align_active == 4'h0 &&
    $past(align_active) == 4'h0 |-> channel_indicator_leds == 4'h0)
    else $error("channel led lit without fault");
endmodule // lcfs_sva
bind lcfs_supervisor lcfs_sva #(.NCH(NCH)) u_sva (.ref_clk, .rst, .reg_rd, .reg_rdata,
  .align_active, .channel_indicator_leds, .fault_led, .fault_out, .standby, .reduced_class,
  .veh_valid, .veh_class, .veh_speed, .rec_valid, .rec_class, .rec_speed, .rec_rows);

// ### testbench/lcfs_front_model.sv
// Front panel observer: counts channel led blinks in each burst.
module lcfs_front_model #(
  parameter SILENT = 2000
) (
  input wire ref_clk,
  input wire [3:0] channel_indicator_leds,
  output logic [15:0] blink_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] prev_q = 4'h0;
  logic [15:0] cnt_q = 16'h0;
  int quiet = 0;
  initial blink_cnt = 16'h0;
  // A long dark gap closes a burst and publishes its per-channel counts.
  always @(posedge ref_clk) begin
    prev_q <= channel_indicator_leds;
    quiet <= (channel_indicator_leds != 4'h0) ? 0 : quiet + 1;
    for (int i = 0; i < 4; i++) begin
      if (channel_indicator_leds[i] && !prev_q[i]) cnt_q[4*i +: 4] <= cnt_q[4*i +: 4] + 4'h1;
    end
    if (quiet == SILENT) begin
      blink_cnt <= cnt_q;
      cnt_q <= 16'h0;
    end
  end
endmodule // lcfs_front_model

// ### testbench/tb_top.sv
// Self-checking bench for the loop channel fault supervisor.
`include "lcfs_map.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h seen %0h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 1;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, jumper_a = 1'b0;
  logic jumper_b = 1'b0, veh_valid = 1'b0, veh_direction = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [3:0] meas_short = 4'h0, meas_open = 4'h0, meas_freq_fail = 4'h0, loop_type_bad = 4'h0;
  logic [3:0] meas_interference = 4'h0, meas_done = 4'h0, align_request = 4'h0, veh_class = 4'h3;
  logic [1:0] veh_system = 2'h2;
  logic [15:0] veh_speed = 16'h02f4, veh_length = 16'h01af, veh_distance = 16'h038e;
  logic [3:0] align_active, channel_indicator_leds, standby, reduced_class, rec_class;
  logic fault_led, fault_out, rec_valid, rec_direction, nv_store;
  logic [1:0] rec_system;
  logic [15:0] rec_speed, rec_length, rec_distance, nv_data, blink_cnt;
  logic [2:0] rec_rows;
  logic [7:0] nv_addr;
  int err_count = 0, compares = 0, cycles = 0;
  lcfs_supervisor #(.NCH(4), .MS_CYCLES(MS)) dut (.ref_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .meas_short, .meas_open, .meas_freq_fail, .meas_interference,
    .meas_done, .loop_type_bad, .jumper_a, .jumper_b, .align_request, .align_active,
    .channel_indicator_leds, .fault_led, .fault_out, .standby, .reduced_class, .veh_valid,
    .veh_system, .veh_class, .veh_speed, .veh_length, .veh_direction, .veh_distance, .rec_valid,
    .rec_system, .rec_class, .rec_speed, .rec_length, .rec_direction, .rec_distance, .rec_rows,
    .nv_store, .nv_addr, .nv_data);
  lcfs_front_model #(.SILENT(1000 * MS)) u_front (.ref_clk, .channel_indicator_leds, .blink_cnt);
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK(n, e, reg_rdata)
  endtask
  task automatic meas(input logic [3:0] m, s, o, f, i);
    @(posedge ref_clk);
    {meas_done, meas_short, meas_open, meas_freq_fail, meas_interference} <= {m, s, o, f, i};
    @(posedge ref_clk);
    {meas_done, meas_short, meas_open, meas_freq_fail, meas_interference} <= 20'h0;
    cyc(3);
  endtask
  task automatic nvchk(input logic [7:0] a, input logic [15:0] e, input string n);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1 k++;
    end while (!(nv_store && nv_addr == a) && k < 40);
    `CHK(n, {1'b1, e}, {nv_store && nv_addr == a, nv_data})
  endtask
  task automatic veh(input logic [7:0] w, input logic [2:0] rows);
    wr(`LCFS_REG_TERMW, {24'h0, w});
    @(posedge ref_clk);
    veh_valid <= 1'b1;
    @(posedge ref_clk);
    veh_valid <= 1'b0;
    #1 `CHK("rec", {1'b1, 2'h2, 4'h3, 16'h02f4}, {rec_valid, rec_system, rec_class, rec_speed})
    `CHK("rec2", {16'h01af, 1'b1, 16'h038e}, {rec_length, rec_direction, rec_distance})
    `CHK("rows", rows, rec_rows)
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    #1 `CHK("reset", {4'hf, 3'h4}, {align_active, rec_rows})
    rd(`LCFS_REG_CTRL, 32'h0, "ctrl");
    rd(`LCFS_REG_MAXALIGN, {16'h0, `LCFS_MAXALIGN_RST_VAL}, "maxalign");
    rd(`LCFS_REG_TERMW, {24'h0, `LCFS_TERMW_RST_VAL}, "termw");
    rd(8'h3c, 32'h0, "unmapped");
    wr(`LCFS_REG_NORM_BASE + 8'h04, 32'h1234);
    wr(`LCFS_REG_THR_BASE, 32'h0abc);
    rd(`LCFS_REG_NORM_BASE + 8'h04, 32'h1234, "norm1");
    rd(`LCFS_REG_THR_BASE, 32'h0abc, "thr0");
    nvchk(8'h02, 16'h1234, "nv_norm1");
    nvchk(8'h01, 16'h0abc, "nv_thr0");
    meas(4'hf, 4'h1, 4'h2, 4'h6, 4'h0);
    rd(`LCFS_REG_FAULT, 32'h321, "codes");
    `CHK("fault", 2'h3, {fault_led, fault_out})
    `CHK("standby", 8'h88, {standby, reduced_class})
    cyc(13500 * MS);
    `CHK("blinks", 16'h0321, blink_cnt)
    wr(`LCFS_REG_MAXALIGN, 32'h1);
    wr(`LCFS_REG_CTRL, 32'h80);
    cyc(995 * MS);
    #1 `CHK("aligning", 1'b1, align_active[3])
    cyc(10 * MS);
    #1 `CHK("aligned", 4'h0, align_active)
    rd(`LCFS_REG_FAULT, 32'h7321, "timeout");
    `CHK("standby2", 4'h0, standby)
    wr(`LCFS_REG_MAXALIGN, 32'h3);
    @(posedge ref_clk);
    align_request <= 4'h8;
    @(posedge ref_clk);
    align_request <= 4'h0;
    cyc(2050 * MS);
    meas(4'h8, 4'h0, 4'h0, 4'h0, 4'h8);
    rd(`LCFS_REG_FAULT, 32'h4321, "disturb");
    wr(`LCFS_REG_CTRL, 32'hf0);
    meas(4'hf, 4'h0, 4'h0, 4'h0, 4'h0);
    rd(`LCFS_REG_FAULT, 32'h0, "clear");
    `CHK("nofault", 2'h0, {fault_led, fault_out})
    jumper_a <= 1'b1;
    cyc(6);
    rd(`LCFS_REG_FAULT, 32'h5555, "jumper");
    `CHK("jfault", 1'b1, fault_out)
    jumper_a <= 1'b0;
    loop_type_bad <= 4'h1;
    cyc(6);
    rd(`LCFS_REG_FAULT, 32'h5555, "both");
    wr(`LCFS_REG_CTRL, 32'h100);
    meas(4'hf, 4'h0, 4'h0, 4'h0, 4'h0);
    rd(`LCFS_REG_FAULT, 32'h8, "looptype");
    veh(8'h10, 3'h4);
    veh(8'h40, 3'h1);
    veh(8'h3f, 3'h4);
    wr(`LCFS_REG_CTRL, 32'h1);
    rd(`LCFS_REG_CTRL, 32'h1, "recal_en");
    cyc(29900 * MS);
    #1 `CHK("recal_wait", 1'b0, align_active[0])
    cyc(200 * MS);
    #1 `CHK("recal_go", 1'b1, align_active[0])
    meas(4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
    rd(`LCFS_REG_FAULT, 32'h8, "recal_keep");
    finish_test();
  end
endmodule // tb_top
